// ### verilog/dwti_pkg.sv
// Shared constants and types for the word transfer DMA interface.
// Assumes one 40 MHz clock; all user and bus inputs are synchronous to it.
`default_nettype none
package dwti_pkg;
    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [2:0] OFF_COUNT = 3'h0;
    localparam logic [2:0] OFF_POINTER = 3'h2;
    localparam logic [2:0] OFF_CSR = 3'h4;
    localparam logic [2:0] OFF_DATA = 3'h6;
    // ----------------------------------------
    // Control register field positions
    // ----------------------------------------
    localparam int B_GO = 0;
    localparam int B_FN_LO = 1;
    localparam int B_XAD_LO = 4;
    localparam int B_IE = 6;
    localparam int B_CYCLE = 8;
    localparam int B_DIAG = 12;
    localparam int B_NEX = 14;
    // ----------------------------------------
    // Reset values and timing
    // ----------------------------------------
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [14:0] RST_POINTER = 15'h0000;
    localparam logic [5:0] RST_UPPER = 6'h00;
    localparam logic [2:0] RST_FN = 3'h0;
    localparam logic [1:0] RST_XAD = 2'h0;
    localparam int CLK_MHZ = 40;
    localparam int NOREPLY_US = 20;
    localparam int NOREPLY_CYC = NOREPLY_US * CLK_MHZ;
    localparam logic [9:0] NOREPLY_LAST = 10'(NOREPLY_CYC - 1);
    localparam logic [1:0] BURST_LAST = 2'h3;
    // ----------------------------------------
    // Cycle kinds chosen by the user control lines
    // ----------------------------------------
    localparam logic [1:0] FN_READ = 2'h0;
    localparam logic [1:0] FN_RMW = 2'h1;
    localparam logic [1:0] FN_WRITE = 2'h2;
    localparam logic [1:0] FN_WRITEB = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_REQ = 3'b001,
        ST_XFER = 3'b011,
        ST_END = 3'b010,
        ST_RMW = 3'b110
    } dwti_state_t;

    typedef struct packed {
        logic [1:0] fn;
        logic count_step_enable;
        logic pointer_step_enable;
        logic byte_select_line;
        logic single;
    } dwti_uctl_t;
endpackage
`default_nettype wire

// ### verilog/dwti_core.sv
// Register file, DMA sequencer and interrupt request of the word transfer interface.
// Assumes a synchronous register port, a simple master port and an ack-style interrupt.
//
// Contract
// - With burst jumper, release and re-request the bus after every four words.
// - Count register holds negative count; steps by one per cycle when enabled.
// - Count reaching zero sets ready at cycle end and may interrupt.
// - Pointer holds word address, steps by two per word when enabled.
// - In narrow mode pointer overflow increments the two control register address bits.
// - In wide mode pointer overflow increments the upper pointer register.
// - In wide mode pointer and upper pointer alternate on one address.
// - In wide mode pointer access sets a select flag; next access or other register clears it.
// - Upper pointer reads always show one in bit 15.
// - Data buffers share an address and take bytes, as does the control register; count and pointer word only.
// - Bit 6 enables interrupts on ready or error becoming set; reset clears.
// - With independent interrupts, user alert requests an interrupt regardless of ready.
// - No reply within 20 us sets bit 14; writing zero clears it.
// - Write half of read-modify-write missing for 20 us sets bit 14.
// - Bit 15 is OR of bits 14 and 13 and forces ready.
// - Bit 13 mirrors user alert; only the user clears it.
// - Start bit reads zero; writing one clears ready and permits transfers.
// - Bits 1 to 3 are user function outputs, cleared by reset.
// - Bits 4 and 5 are address bits, read-only in wide mode.
// - Ready set by reset, count overflow and error; cleared by start.
// - Bit 8 primes a cycle; set by user request or software.
// - Bits 9 to 11 mirror the user status inputs.
// - Input data and user controls latched as busy falls.
// - Interrupt acknowledge returns the vector with reply and drops the request.
// - Enabling interrupts without start gives no interrupt.
`default_nettype none
module dwti_core
    import dwti_pkg::*;
#(
    // Arbitrary vector value
    parameter logic [15:0] IRQ_VECTOR = 16'h0080
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Register port
    input wire logic [2:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [1:0] reg_be,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_reply,
    // Interrupt
    output logic bus_irq_request,
    input wire logic irq_ack,
    // Bus master
    output logic m_req,
    input wire logic m_grant,
    output logic m_master,
    output logic [21:0] m_addr,
    output logic m_rd,
    output logic m_wr,
    output logic m_byte,
    output logic [15:0] m_wdata,
    input wire logic [15:0] m_rdata,
    input wire logic m_reply,
    // User device
    input wire logic cycle_request,
    input wire dwti_uctl_t uctl,
    input wire logic [15:0] user_in_data,
    output logic [15:0] user_out_data,
    output logic busy_n,
    output logic ready,
    output logic [2:0] user_function_bits,
    input wire logic [2:0] user_status_input,
    input wire logic user_alert,
    // Jumpers
    input wire logic four_word_burst_jumper,
    input wire logic wide_address_mode,
    input wire logic indep_irq_jumper
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    dwti_state_t state_reg;
    dwti_uctl_t uctl_reg;
    logic [15:0] count_reg;
    logic [14:0] pointer_reg;
    logic [5:0] upper_reg;
    logic [2:0] fn_reg;
    logic [1:0] xad_reg;
    logic ie_reg, ready_reg, cycle_reg, diag_reg, nex_reg;
    logic upper_sel_reg, rmw_half_reg, pending_reg;
    logic ready_q_reg, err_q_reg, alert_q_reg;
    logic [15:0] in_buf_reg, out_buf_reg, rdata_reg;
    logic reply_reg;
    logic [9:0] timer_reg;
    logic [1:0] burst_reg;

    logic access, to_upper, sw_count, sw_ptr, sw_upper, sw_csr_lo, sw_csr_hi;
    logic error, ready_rd, start, step, count_ovf, ptr_ovf, timeout, go_on;
    logic irq_event;
    logic [15:0] csr_rd, rd_mux;

    assign access = reg_rd | reg_wr;
    assign to_upper = wide_address_mode && upper_sel_reg && reg_addr[2:1] == OFF_POINTER[2:1];
    assign sw_count = reg_wr && reg_be == 2'h3 && reg_addr[2:1] == OFF_COUNT[2:1];
    assign sw_ptr = reg_wr && reg_be == 2'h3 && reg_addr[2:1] == OFF_POINTER[2:1] && !to_upper;
    assign sw_upper = reg_wr && reg_be == 2'h3 && to_upper;
    assign sw_csr_lo = reg_wr && reg_be[0] && reg_addr[2:1] == OFF_CSR[2:1];
    assign sw_csr_hi = reg_wr && reg_be[1] && reg_addr[2:1] == OFF_CSR[2:1];

    assign error = nex_reg | user_alert;
    assign ready_rd = ready_reg | error;
    assign ready = ready_rd;
    assign start = state_reg == ST_IDLE && cycle_reg && !ready_rd;
    assign step = state_reg == ST_END;
    assign count_ovf = step && uctl_reg.count_step_enable && count_reg == 16'hffff;
    assign ptr_ovf = step && uctl_reg.pointer_step_enable && pointer_reg == 15'h7fff;
    assign timeout = timer_reg == NOREPLY_LAST;
    assign go_on = !uctl_reg.single && !count_ovf && !error;

    // ----------------------------------------
    // Bus master outputs
    // ----------------------------------------
    // byte select from the user
    assign m_addr = wide_address_mode ?
        {upper_reg, pointer_reg, uctl_reg.byte_select_line} :
        {4'h0, xad_reg, pointer_reg, uctl_reg.byte_select_line};
    assign m_req = state_reg == ST_REQ;
    assign m_master = state_reg == ST_XFER || state_reg == ST_RMW || state_reg == ST_END;
    assign m_rd = state_reg == ST_XFER &&
        (uctl_reg.fn == FN_READ || (uctl_reg.fn == FN_RMW && !rmw_half_reg));
    assign m_wr = state_reg == ST_XFER && !m_rd;
    assign m_byte = uctl_reg.fn == FN_WRITEB;
    assign m_wdata = in_buf_reg;
    assign busy_n = state_reg == ST_IDLE;
    assign user_out_data = out_buf_reg;
    assign user_function_bits = fn_reg;
    assign bus_irq_request = pending_reg;
    assign reg_rdata = rdata_reg;
    assign reg_reply = reply_reg;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_reg <= ST_IDLE;
            rmw_half_reg <= 1'b0;
            burst_reg <= 2'h0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    rmw_half_reg <= 1'b0;
                    burst_reg <= 2'h0;
                    if (start) begin
                        state_reg <= ST_REQ;
                    end
                end
                ST_REQ: begin
                    burst_reg <= 2'h0;
                    if (m_grant) begin
                        state_reg <= ST_XFER;
                    end
                end
                ST_XFER: begin
                    if (m_reply) begin
                        state_reg <= (m_rd && uctl_reg.fn == FN_RMW) ? ST_RMW : ST_END;
                    end else if (timeout) begin
                        state_reg <= ST_END;
                    end
                end
                ST_RMW: begin
                    // write half must follow in time
                    if (cycle_request) begin
                        rmw_half_reg <= 1'b1;
                        state_reg <= ST_XFER;
                    end else if (timeout) begin
                        state_reg <= ST_END;
                    end
                end
                ST_END: begin
                    rmw_half_reg <= 1'b0;
                    burst_reg <= burst_reg + 2'h1;
                    if (!go_on) begin
                        state_reg <= ST_IDLE;
                    end else if (four_word_burst_jumper && burst_reg == BURST_LAST) begin
                        state_reg <= ST_REQ;
                    end else begin
                        state_reg <= ST_XFER;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Reply watchdog, restarted on every state change
    always_ff @(posedge clock) begin
        if (!rstn || (state_reg != ST_XFER && state_reg != ST_RMW)) begin
            timer_reg <= 10'h000;
        end else if ((state_reg == ST_XFER && m_reply) || (state_reg == ST_RMW && cycle_request)
                     || timeout) begin
            timer_reg <= 10'h000;
        end else begin
            timer_reg <= timer_reg + 10'h001;
        end
    end

    // latch data and controls as busy falls
    always_ff @(posedge clock) begin
        if (!rstn) begin
            uctl_reg <= '0;
            in_buf_reg <= 16'h0000;
        end else if (start || (state_reg == ST_RMW && cycle_request)) begin
            uctl_reg <= uctl;
            in_buf_reg <= user_in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            out_buf_reg <= 16'h0000;
        end else if (m_rd && m_reply) begin
            out_buf_reg <= m_rdata;
        end else if (reg_wr && reg_addr[2:1] == OFF_DATA[2:1]) begin
            // byte lanes on the outbound buffer
            if (reg_be[0]) out_buf_reg[7:0] <= reg_wdata[7:0];
            if (reg_be[1]) out_buf_reg[15:8] <= reg_wdata[15:8];
        end
    end

    // ----------------------------------------
    // Count, pointer and upper address
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            count_reg <= RST_COUNT;
        end else if (sw_count) begin
            count_reg <= reg_wdata;
        end else if (step && uctl_reg.count_step_enable) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            pointer_reg <= RST_POINTER;
        end else if (sw_ptr) begin
            pointer_reg <= reg_wdata[15:1];
        end else if (step && uctl_reg.pointer_step_enable) begin
            pointer_reg <= pointer_reg + 15'h0001;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            upper_reg <= RST_UPPER;
        end else if (sw_upper) begin
            upper_reg <= reg_wdata[5:0];
        end else if (ptr_ovf && wide_address_mode) begin
            upper_reg <= upper_reg + 6'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            xad_reg <= RST_XAD;
        // carry into the control register bits
        end else if (ptr_ovf && !wide_address_mode) begin
            xad_reg <= xad_reg + 2'h1;
        end else if (sw_csr_lo && !wide_address_mode) begin
            xad_reg <= reg_wdata[B_XAD_LO +: 2];
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            upper_sel_reg <= 1'b0;
        end else if (access) begin
            upper_sel_reg <= wide_address_mode && reg_addr[2:1] == OFF_POINTER[2:1]
                && !upper_sel_reg;
        end
    end

    // ----------------------------------------
    // Control register bits
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            fn_reg <= RST_FN;
            ie_reg <= 1'b0;
            diag_reg <= 1'b0;
        end else begin
            if (sw_csr_lo) fn_reg <= reg_wdata[B_FN_LO +: 3];
            if (sw_csr_lo) ie_reg <= reg_wdata[B_IE];
            if (sw_csr_hi) diag_reg <= reg_wdata[B_DIAG];
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            ready_reg <= 1'b1;
        end else if (count_ovf || error) begin
            ready_reg <= 1'b1;
        end else if (sw_csr_lo && reg_wdata[B_GO]) begin
            ready_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            nex_reg <= 1'b0;
        end else if (timeout) begin
            nex_reg <= 1'b1;
        end else if (sw_csr_hi && !reg_wdata[B_NEX]) begin
            nex_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            cycle_reg <= 1'b0;
        end else if (cycle_request || (sw_csr_hi && reg_wdata[B_CYCLE])) begin
            cycle_reg <= 1'b1;
        end else if (start) begin
            cycle_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Interrupt request
    // ----------------------------------------
    // only rising conditions request; enable alone does not
    assign irq_event = ie_reg && ((ready_rd && !ready_q_reg) || (error && !err_q_reg)
        || (indep_irq_jumper && user_alert && !alert_q_reg));

    always_ff @(posedge clock) begin
        if (!rstn) begin
            ready_q_reg <= 1'b1;
            err_q_reg <= 1'b0;
            alert_q_reg <= 1'b0;
        end else begin
            ready_q_reg <= ready_rd;
            err_q_reg <= error;
            alert_q_reg <= user_alert;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            pending_reg <= 1'b0;
        end else if (irq_event) begin
            pending_reg <= 1'b1;
        end else if (irq_ack) begin
            pending_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Read data and reply
    // ----------------------------------------
    // live status bits, start reads zero
    assign csr_rd = {error, nex_reg, user_alert, diag_reg, user_status_input, cycle_reg,
                     ready_rd, ie_reg, xad_reg, fn_reg, 1'b0};

    always_comb begin
        unique case (reg_addr[2:1])
            OFF_COUNT[2:1]: rd_mux = count_reg;
            // upper reads one in bit 15
            OFF_POINTER[2:1]: rd_mux = to_upper ? {1'b1, 9'h000, upper_reg} : {pointer_reg, 1'b0};
            OFF_CSR[2:1]: rd_mux = csr_rd;
            OFF_DATA[2:1]: rd_mux = in_buf_reg;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            rdata_reg <= 16'h0000;
            reply_reg <= 1'b0;
        end else begin
            reply_reg <= access || irq_ack;
            if (irq_ack) rdata_reg <= IRQ_VECTOR;
            else if (reg_rd) rdata_reg <= rd_mux;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    a_count_step: assert property (step && uctl_reg.count_step_enable && !sw_count
        |=> count_reg == $past(count_reg) + 16'h0001) else $error("count did not step");
    a_count_ready: assert property (count_ovf |=> ready_rd && count_reg == 16'h0000)
        else $error("count overflow missed ready");
    a_ptr_step: assert property (step && uctl_reg.pointer_step_enable && !sw_ptr
        |=> pointer_reg == $past(pointer_reg) + 15'h0001) else $error("pointer did not step");
    a_xad_carry: assert property (ptr_ovf && !wide_address_mode && !sw_ptr
        |=> pointer_reg == 15'h0 && xad_reg == $past(xad_reg) + 2'h1) else $error("xad carry");
    a_upper_carry: assert property (ptr_ovf && wide_address_mode && !sw_upper && !sw_ptr
        |=> upper_reg == $past(upper_reg) + 6'h01) else $error("upper carry");
    a_upper_bit15: assert property (reg_rd && to_upper |=> reg_rdata[15])
        else $error("upper bit 15 not one");
    a_noreply_time: assert property ($rose(state_reg == ST_XFER) ##0
        (state_reg == ST_XFER && !m_reply) [*8] |=> timer_reg == 10'h008)
        else $error("watchdog not counting");
    a_noreply_set: assert property (timeout |=> nex_reg && state_reg == ST_END)
        else $error("no-reply not flagged");
    a_error_csr: assert property (reg_rd && reg_addr[2:1] == OFF_CSR[2:1] && error
        |=> reg_rdata[15] && reg_rdata[7] && !reg_rdata[0]) else $error("error readback");
    a_burst_release: assert property (step && go_on && four_word_burst_jumper
        && burst_reg == BURST_LAST |=> m_req && !m_master) else $error("burst not released");
    a_busy_latch: assert property (start |=> !busy_n && in_buf_reg == $past(user_in_data))
        else $error("input not latched");
    a_ack_vector: assert property (irq_ack && !irq_event
        |=> reg_reply && reg_rdata == IRQ_VECTOR && !bus_irq_request) else $error("ack");
    a_ie_alone: assert property (sw_csr_lo && reg_wdata[B_IE] && !reg_wdata[B_GO]
        && ready_rd && $stable(error) && !user_alert && !pending_reg && !ie_reg
        |=> !bus_irq_request) else $error("spurious interrupt");

    c_count_done: cover property (count_ovf ##1 bus_irq_request);
    c_noreply: cover property (timeout && state_reg == ST_XFER);
    c_rmw: cover property (state_reg == ST_RMW ##[1:20] m_wr && m_reply);
    c_burst_release: cover property (step && burst_reg == BURST_LAST ##1 m_req);
endmodule
`default_nettype wire

// ### verif/dwti_host_mem.sv
// Host memory and bus arbiter model facing the device master port.
// Assumes the device holds m_rd or m_wr until it has seen m_reply.
`default_nettype none
module dwti_host_mem (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Master port of the device
    input wire logic m_req,
    output logic m_grant,
    input wire logic [21:0] m_addr,
    input wire logic m_rd,
    input wire logic m_wr,
    input wire logic [15:0] m_wdata,
    output logic [15:0] m_rdata,
    output logic m_reply,
    // Scenario controls
    input wire logic [3:0] lag,
    input wire logic mute
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [16];
    logic [3:0] wait_reg;
    // Reply comes late by lag cycles, or never while muted
    always_ff @(posedge clock) begin
        m_grant <= rstn && m_req;
        wait_reg <= ((m_rd || m_wr) && !m_reply) ? wait_reg + 4'h1 : 4'h0;
        m_reply <= rstn && (m_rd || m_wr) && !m_reply && !mute && wait_reg >= lag;
        if (m_wr && m_reply) begin
            mem[m_addr[4:1]] <= m_wdata;
        end
    end
    // Outside a reply the data lines never show the stored word
    assign m_rdata = m_reply ? mem[m_addr[4:1]] : ~mem[m_addr[4:1]];
endmodule
`default_nettype wire

// ### verif/dwti_core_tb.sv
// Self-checking bench for the word transfer DMA interface.
// Assumes the host memory model answers the master port; the bench is host and user.
`default_nettype none
module dwti_core_tb;
    import dwti_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] VEC = 16'h0124;
    logic clock, rstn, reg_rd, reg_wr, reg_reply, bus_irq_request, irq_ack;
    logic m_req, m_grant, m_master, m_rd, m_wr, m_byte, m_reply, mute;
    logic cycle_request, busy_n, ready, user_alert, four_word_burst_jumper;
    logic wide_address_mode, indep_irq_jumper;
    logic [2:0] reg_addr, user_function_bits, user_status_input;
    logic [1:0] reg_be;
    logic [15:0] reg_wdata, reg_rdata, m_wdata, m_rdata, user_in_data, user_out_data;
    logic [21:0] m_addr;
    dwti_uctl_t uctl;
    int fail_count, n_tests, cycles;
    dwti_core #(.IRQ_VECTOR(VEC)) dwti_core_i (.clock, .rstn, .reg_addr, .reg_rd,
        .reg_wr, .reg_be, .reg_wdata, .reg_rdata, .reg_reply, .bus_irq_request,
        .irq_ack, .m_req, .m_grant, .m_master, .m_addr, .m_rd, .m_wr, .m_byte,
        .m_wdata, .m_rdata, .m_reply, .cycle_request, .uctl, .user_in_data,
        .user_out_data, .busy_n, .ready, .user_function_bits, .user_status_input,
        .user_alert, .four_word_burst_jumper, .wide_address_mode, .indep_irq_jumper);
    dwti_host_mem dwti_host_mem_i (.clock, .rstn, .m_req, .m_grant, .m_addr, .m_rd,
        .m_wr, .m_wdata, .m_rdata, .m_reply, .lag(4'h2), .mute);
    // ----
    // Shared tasks
    // ----
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask
    task automatic acc(input logic wr, input logic [2:0] a, input logic [1:0] be,
            input logic [15:0] d);
        @(posedge clock);
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_addr <= a;
        reg_be <= be;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        chk({15'h0000, reg_reply}, 16'h0001);
    endtask
    task automatic rd(input logic [2:0] a, input logic [15:0] exp);
        acc(1'b0, a, 2'h3, 16'h0000);
        chk(reg_rdata, exp);
    endtask
    // Changes the user data once busy falls, so a late latch is seen
    task automatic word(input logic [1:0] fn, input logic ps, input logic sg,
            input logic [15:0] d);
        @(posedge clock);
        // user drives the byte select line
        uctl <= {fn, 1'b1, ps, 1'b0, sg};
        user_in_data <= d;
        cycle_request <= 1'b1;
        @(posedge clock);
        cycle_request <= 1'b0;
        for (int i = 0; i < 1000 && busy_n !== 1'b0; i++) @(posedge clock);
        user_in_data <= ~d;
        for (int i = 0; i < 1000 && busy_n !== 1'b1; i++) @(posedge clock);
        #1;
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_reset;
        rd(OFF_CSR, 16'h0a80);
        acc(1'b1, OFF_CSR, 2'h1, 16'h004e);
        chk({13'h0000, user_function_bits}, 16'h0007);
        repeat (4) @(posedge clock);
        chk({15'h0000, bus_irq_request}, 16'h0000);
        rd(OFF_CSR, 16'h0ace);
        acc(1'b1, OFF_CSR, 2'h1, 16'h0000);
    endtask
    task automatic t_regs;
        acc(1'b1, OFF_COUNT, 2'h1, 16'h0033);
        rd(OFF_COUNT, 16'h0000);
        acc(1'b1, OFF_DATA, 2'h2, 16'hab12);
        chk(user_out_data, 16'hab00);
        rd(OFF_DATA, 16'h0000);
        wide_address_mode <= 1'b1;
        acc(1'b1, OFF_POINTER, 2'h3, 16'h0234);
        acc(1'b1, OFF_POINTER, 2'h3, 16'h0005);
        rd(OFF_COUNT, 16'h0000);
        rd(OFF_POINTER, 16'h0234);
        rd(OFF_POINTER, 16'h8005);
        acc(1'b1, OFF_CSR, 2'h1, 16'h0070);
        rd(OFF_CSR, 16'h0ac0);
        @(posedge clock);
        wide_address_mode <= 1'b0;
    endtask
    task automatic t_dma;
        acc(1'b1, OFF_COUNT, 2'h3, 16'hfffe);
        acc(1'b1, OFF_CSR, 2'h1, 16'h0041);
        chk({15'h0000, ready}, 16'h0000);
        word(FN_WRITE, 1'b0, 1'b1, 16'h5a3c);
        rd(OFF_COUNT, 16'hffff);
        rd(OFF_POINTER, 16'h0234);
        word(FN_READ, 1'b1, 1'b1, 16'h0000);
        chk(user_out_data, 16'h5a3c);
        rd(OFF_POINTER, 16'h0236);
        rd(OFF_COUNT, 16'h0000);
        chk({14'h0000, ready, bus_irq_request}, 16'h0003);
        @(posedge clock);
        irq_ack <= 1'b1;
        @(posedge clock);
        irq_ack <= 1'b0;
        #1;
        chk(reg_rdata, VEC);
        chk({14'h0000, reg_reply, bus_irq_request}, 16'h0002);
    endtask
    // Five-word burst from the top of the pointer: carry, then a release after four
    task automatic t_burst;
        four_word_burst_jumper <= 1'b1;
        for (int m = 0; m < 2; m++) begin
            wide_address_mode <= m[0];
            acc(1'b1, OFF_COUNT, 2'h3, 16'hfffb);
            acc(1'b1, OFF_POINTER, 2'h3, 16'hfffe);
            acc(1'b1, OFF_CSR, 2'h1, 16'h0041);
            word(m[0] ? FN_WRITEB : FN_WRITE, 1'b1, 1'b0, 16'h1234);
            chk({15'h0000, m_byte}, {15'h0000, m[0]});
            rd(OFF_COUNT, 16'h0000);
            rd(OFF_POINTER, 16'h0008);
            if (m == 0) rd(OFF_CSR, 16'h0ad0);
            else rd(OFF_POINTER, 16'h8006);
        end
        wide_address_mode <= 1'b0;
        four_word_burst_jumper <= 1'b0;
    endtask
    task automatic t_fault;
        mute <= 1'b1;
        acc(1'b1, OFF_CSR, 2'h1, 16'h0041);
        word(FN_READ, 1'b1, 1'b1, 16'h0000);
        rd(OFF_CSR, 16'hcac0);
        chk({15'h0000, bus_irq_request}, 16'h0001);
        mute <= 1'b0;
        acc(1'b1, OFF_CSR, 2'h2, 16'h0000);
        rd(OFF_CSR, 16'h0ac0);
        // Read half answered, write half never requested
        acc(1'b1, OFF_CSR, 2'h1, 16'h0041);
        word(FN_RMW, 1'b1, 1'b1, 16'h0000);
        rd(OFF_CSR, 16'hcac0);
        acc(1'b1, OFF_CSR, 2'h2, 16'h0000);
        user_alert <= 1'b1;
        rd(OFF_CSR, 16'haac0);
    endtask
    // ----
    // Clock, reset, sequence and watchdog
    // ----
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    initial begin
        {rstn, reg_rd, reg_wr, irq_ack, mute, cycle_request, user_alert} = '0;
        {four_word_burst_jumper, wide_address_mode, indep_irq_jumper} = '0;
        {reg_addr, reg_be, reg_wdata, user_in_data} = '0;
        uctl = '0;
        user_status_input = 3'h5;
        repeat (20) @(posedge clock);
        rstn <= 1'b1;
        t_reset();
        t_regs();
        t_dma();
        t_burst();
        t_fault();
        complete_run();
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            complete_run();
        end
    end
endmodule
`default_nettype wire
